// ===== dv/sbc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the byte register port and the apply strobes
module sbc_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       refused_in,
  output logic            ce_out,
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic [7:0]      wdata_out,
  output logic            rd_out,
  output logic            unlock_out,
  output logic            apply_out,
  output logic            noslew_out
);
  // idle values at time zero
  initial begin
    ce_out = 1'b1;
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
    unlock_out = 1'b0;
    apply_out = 1'b0;
    noslew_out = 1'b0;
  end
  // one byte write; unlock level chosen by caller
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d, input logic unl, output logic refused);
    @(negedge clk_in);
    unlock_out = unl;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    refused = refused_in;
    wr_out = 1'b0;
    addr_out = ~a; // released lines show the inverse
    wdata_out = ~d;
  endtask
  // one byte read, data sampled half a cycle after the taking edge
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    d = rdata_in;
    rd_out = 1'b0;
    addr_out = ~a;
  endtask
  // apply strobe, slewed or not
  task automatic apply(input logic ns);
    @(negedge clk_in);
    apply_out = ~ns;
    noslew_out = ns;
    @(negedge clk_in);
    apply_out = 1'b0;
    noslew_out = 1'b0;
  endtask
  // clock enable level, changed off the sampling edge
  task automatic set_ce(input logic v);
    @(negedge clk_in);
    ce_out = v;
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sbc_pkg::*;
  localparam int unsigned BLANK = 20;
  logic clk, rst, pfo_n, ce, wr, rd, unl, ap, ns, refd, pskip, nosl, blank, f;
  logic [7:0] addr, wdata, rdata, d;
  logic [2:0] ls_on, disch;
  logic [5:0] vcode;
  logic [10:0] mv;
  logic [2:0] ls_en;
  logic [31:0] r;
  int edge_codes [$];
  int num_errors, samples_checked, cycles, sw_m, buck_m, code_m, i;

  // free running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  sbc_host host (.clk_in(clk), .rdata_in(rdata), .refused_in(refd), .ce_out(ce), .addr_out(addr),
    .wr_out(wr), .wdata_out(wdata), .rd_out(rd), .unlock_out(unl), .apply_out(ap), .noslew_out(ns));

  sbc_top #(.BLANK_CYCLES(BLANK)) dut (.REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .PW_UNLOCK_IN(unl), .APPLY_IN(ap),
    .APPLY_NOSLEW_IN(ns), .PFO_N_IN(pfo_n), .LS_EN_IN(ls_en), .REG_RDATA_OUT(rdata),
    .WR_REFUSED_OUT(refd), .LS_ON_OUT(ls_on), .LS_DISCHARGE_OUT(disch), .PULSE_SKIP_OUT(pskip),
    .BUCK_VCODE_OUT(vcode), .BUCK_MV_OUT(mv), .NO_SLEW_OUT(nosl), .SUPV_BLANK_OUT(blank));

  // stimulus source
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // model millivolts: fine steps to the knee, wide steps above
  function automatic int mv_of(input int c);
    return (c <= 'h32) ? 850 + 10 * c : 1350 + 25 * (c - 'h32);
  endfunction
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      results;
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    pfo_n = 1'b1;
    ls_en = 3'h0;
    r = 32'h7958;
    edge_codes = '{'h00, 'h23, 'h32, 'h33, 'h3f};
    sw_m = 0;
    buck_m = 'h99;
    code_m = 'h19;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk("vcode", 11'(code_m), 11'(vcode));
    chk("mv", 11'(mv_of(code_m)), mv);
    chk("pskip", 11'h001, 11'(pskip));
    host.rd_byte(8'h15, d);
    chk("cfg", 11'(sw_m), 11'(d));
    host.rd_byte(8'h16, d);
    chk("buck", 11'(buck_m), 11'(d));
    // locked write is dropped
    host.wr_byte(8'h16, 8'h00, 1'b0, f);
    chk("refused", 11'h001, 11'(f));
    chk("blank", 11'h000, 11'(blank));
    host.rd_byte(8'h16, d);
    chk("buck", 11'(buck_m), 11'(d));
    // buck writes, apply, readback, unmapped read
    for (i = 0; i < 12; i++) begin
      r = lfsr(r);
      d = r[7:0];
      if (i < edge_codes.size()) d[5:0] = 6'(edge_codes[i]);
      host.wr_byte(8'h16, d, 1'b1, f);
      chk("refused", 11'h000, 11'(f));
      buck_m = d & 8'hbf;
      chk("blank", 11'h001, 11'(blank));
      chk("pskip", 11'(d[7]), 11'(pskip));
      chk("vcode", 11'(code_m), 11'(vcode));
      host.apply(i[0]);
      code_m = buck_m & 'h3f;
      chk("vcode", 11'(code_m), 11'(vcode));
      chk("mv", 11'(mv_of(code_m)), mv);
      chk("noslew", 11'(i[0]), 11'(nosl));
      host.rd_byte(8'h16, d);
      chk("buck", 11'(buck_m), 11'(d));
      host.wr_byte(8'h15, r[15:8], 1'b1, f);
      sw_m = r[15:8] & 8'h3f;
      host.rd_byte(8'h15, d);
      chk("cfg", 11'(sw_m), 11'(d));
      host.rd_byte(8'h17 + 8'(i), d);
      chk("unmapped", 11'h000, 11'(d));
    end
    // blanking length after one write
    host.wr_byte(8'h16, 8'(buck_m), 1'b1, f);
    repeat (BLANK - 1) @(negedge clk);
    chk("blank", 11'h001, 11'(blank));
    repeat (1) @(negedge clk);
    chk("blank", 11'h000, 11'(blank));
    // frozen clock enable: an unlocked write leaves no trace
    host.set_ce(1'b0);
    host.wr_byte(8'h16, ~8'(buck_m), 1'b1, f);
    chk("refused", 11'h000, 11'(f));
    chk("blank", 11'h000, 11'(blank));
    host.set_ce(1'b1);
    host.rd_byte(8'h16, d);
    chk("buck", 11'(buck_m), 11'(d));
    // switch gating and discharge against the model
    for (i = 0; i < 16; i++) begin
      r = lfsr(r);
      host.wr_byte(8'h15, {2'b00, r[5:0]}, 1'b1, f);
      sw_m = r[5:0];
      @(negedge clk);
      ls_en = r[10:8];
      pfo_n = r[11];
      repeat (4) @(negedge clk);
      d[2:0] = r[10:8] & ~(3'(sw_m >> 3) & {3{~r[11]}});
      chk("ls_on", 11'(d[2:0]), 11'(ls_on));
      chk("disch", 11'(3'(sw_m) & ~d[2:0]), 11'(disch));
    end
    results;
  end
endmodule
`default_nettype wire

// ===== hdl/sbc_blank_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.svh"
// holds supervisor blanking for a fixed count after each start
module sbc_blank_timer #(
  parameter int unsigned BLANK_CYCLES = `SBC_BLANK_CYCLES
) (
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  sbc_ctl_if.timer    ctl
);
  import sbc_pkg::*;
  logic [`SBC_BLANK_CNT_W-1:0] cnt_reg;
  logic                        blank_reg;
  logic [`SBC_BLANK_CNT_W-1:0] cnt_load;

  assign cnt_load  = `SBC_BLANK_CNT_W'(BLANK_CYCLES - 1);
  assign ctl.blank = blank_reg;

  // a new start retriggers the full interval
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg   <= '0;
      blank_reg <= 1'b0;
    end else if (ctl.ce) begin
      if (ctl.start) begin
        cnt_reg   <= cnt_load;  // RULE11
        blank_reg <= 1'b1;  // RULE11
      end else if (cnt_reg != '0) begin
        cnt_reg   <= cnt_reg - 1'b1;
      end else begin
        blank_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_blank_hold;
    ctl.ce && blank_reg && cnt_reg != '0 |=> blank_reg;
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("blanking ended early");  // RULE11

  property p_blank_end;
    ctl.ce && !ctl.start && cnt_reg == '0 |=> !blank_reg;
  endproperty
  a_blank_end: assert property (p_blank_end) else $error("blanking outlived count");  // RULE11
endmodule
`default_nettype wire

// ===== hdl/sbc_top.sv
// Contract
// RULE1 - protected registers written only while unlocked
// RULE2 - switch config at 0x15, resets zero
// RULE3 - bit5 set: power fail turns switch three off
// RULE4 - bit4 set: power fail turns switch two off
// RULE5 - bit3 set: power fail turns switch one off
// RULE6 - bit clear: switch ignores power fail
// RULE7 - bit2: discharge switch three while off
// RULE8 - bit1: discharge switch two while off
// RULE9 - bit0: discharge switch one while off
// RULE10 - buck register at 0x16, resets 0x99
// RULE11 - buck write blanks supervision five milliseconds
// RULE12 - new voltage only after apply strobe
// RULE13 - bit7 selects pulse-skip, resets one
// RULE14 - bits5-0 voltage code, 0.85V plus 10mV
// RULE15 - above 32h, 25mV steps to 1.675V
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.svh"
module sbc_top #(
  parameter int unsigned BLANK_CYCLES = `SBC_BLANK_CYCLES
) (
  input  wire logic             REF_CLK_IN,
  input  wire logic             RST_IN,
  input  wire logic             CE_IN,
  input  wire sbc_pkg::sbc_byte_t REG_ADDR_IN,
  input  wire logic             REG_WR_IN,
  input  wire sbc_pkg::sbc_byte_t REG_WDATA_IN,
  input  wire logic             REG_RD_IN,
  input  wire logic             PW_UNLOCK_IN,
  input  wire logic             APPLY_IN,
  input  wire logic             APPLY_NOSLEW_IN,
  input  wire logic             PFO_N_IN,
  input  wire sbc_pkg::sbc_sw_t LS_EN_IN,
  output logic [7:0]            REG_RDATA_OUT,
  output logic                  WR_REFUSED_OUT,
  output logic [2:0]            LS_ON_OUT,
  output logic [2:0]            LS_DISCHARGE_OUT,
  output logic                  PULSE_SKIP_OUT,
  output logic [5:0]            BUCK_VCODE_OUT,
  output logic [10:0]           BUCK_MV_OUT,
  output logic                  NO_SLEW_OUT,
  output logic                  SUPV_BLANK_OUT
);
  import sbc_pkg::*;

  // address match shared by read and write decode
  function automatic logic addr_hit(input sbc_byte_t a, input sbc_byte_t want);
    return a == want;
  endfunction

  sbc_ctl_if ctl ();

  // power-fail pin synchroniser
  logic      pfo_meta_reg;
  logic      pfo_sync_reg;
  logic      pfo_low;

  // register storage
  sbc_byte_t sw_cfg_reg;
  sbc_byte_t sw_cfg_next;
  sbc_byte_t buck_reg;
  sbc_byte_t buck_next;
  sbc_vcode_t vcode_reg;
  sbc_vcode_t vcode_next;
  logic      no_slew_reg;
  logic      no_slew_next;
  sbc_mv_t   mv_reg;
  sbc_byte_t rdata_reg;
  sbc_byte_t rdata_next;
  logic      refused_reg;

  // switch outputs
  sbc_sw_t   ls_on_reg;
  sbc_sw_t   ls_on_next;
  sbc_sw_t   dch_reg;
  sbc_sw_t   dch_next;

  // decode wires
  logic      hit_sw;
  logic      hit_buck;
  logic      wr_sw;
  logic      wr_buck;
  logic      wr_prot;
  logic      wr_sw_ok;
  logic      wr_buck_ok;
  logic      wr_locked;
  logic      apply;
  sbc_sw_t   pf_off_en;
  sbc_sw_t   dch_en;
  sbc_sw_t   pf_kill;

  // two flops before any logic sees the pin
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      pfo_meta_reg <= 1'b1;
      pfo_sync_reg <= 1'b1;
    end else if (CE_IN) begin
      pfo_meta_reg <= PFO_N_IN;
      pfo_sync_reg <= pfo_meta_reg;
    end
  end

  assign pfo_low = ~pfo_sync_reg;

  // address and write decode
  assign hit_sw     = addr_hit(REG_ADDR_IN, `SBC_ADDR_SW_CFG);  // RULE2
  assign hit_buck   = addr_hit(REG_ADDR_IN, `SBC_ADDR_BUCK1);  // RULE10
  assign wr_sw      = REG_WR_IN & hit_sw;
  assign wr_buck    = REG_WR_IN & hit_buck;
  assign wr_prot    = wr_sw | wr_buck;
  assign wr_sw_ok   = wr_sw & PW_UNLOCK_IN;  // RULE1
  assign wr_buck_ok = wr_buck & PW_UNLOCK_IN;  // RULE1
  assign wr_locked  = wr_prot & ~PW_UNLOCK_IN;  // RULE1

  // register next values, reserved bits forced low
  assign sw_cfg_next = wr_sw_ok ? (REG_WDATA_IN & `SBC_SW_CFG_MASK) : sw_cfg_reg;
  assign buck_next   = wr_buck_ok ? (REG_WDATA_IN & `SBC_BUCK1_MASK) : buck_reg;

  // applied voltage follows the stored code only on an apply strobe
  assign apply        = APPLY_IN | APPLY_NOSLEW_IN;
  assign vcode_next   = apply ? buck_reg[`SBC_VCODE_HI:0] : vcode_reg;  // RULE12
  assign no_slew_next = apply ? APPLY_NOSLEW_IN : no_slew_reg;
  assign ctl.code     = vcode_next;  // RULE14

  // load switch gating and discharge
  assign pf_off_en  = sw_cfg_reg[`SBC_OFF_HI:`SBC_OFF_LO];
  assign dch_en     = sw_cfg_reg[`SBC_DCH_HI:`SBC_DCH_LO];
  assign pf_kill    = pf_off_en & {3{pfo_low}};  // RULE3 RULE4 RULE5
  assign ls_on_next = LS_EN_IN & ~pf_kill;  // RULE6
  assign dch_next   = dch_en & ~ls_on_next;  // RULE7 RULE8 RULE9

  // read mux, unmapped reads return zero
  assign rdata_next = hit_sw   ? sw_cfg_reg :
                      hit_buck ? buck_reg   : 8'h00;

  // blank timer control
  assign ctl.ce    = CE_IN;
  assign ctl.start = wr_buck_ok;  // RULE11

  // configuration registers
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      sw_cfg_reg <= `SBC_SW_CFG_RST;  // RULE2
      buck_reg   <= `SBC_BUCK1_RST;  // RULE10 RULE13 RULE14
    end else if (CE_IN) begin
      sw_cfg_reg <= sw_cfg_next;
      buck_reg   <= buck_next;
    end
  end

  // applied voltage state
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      vcode_reg   <= `SBC_VCODE_RST;
      no_slew_reg <= 1'b0;
      mv_reg      <= `SBC_MV_RST;
    end else if (CE_IN) begin
      vcode_reg   <= vcode_next;  // RULE12
      no_slew_reg <= no_slew_next;
      mv_reg      <= ctl.mv;  // RULE15
    end
  end

  // switch state
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      ls_on_reg <= '0;
      dch_reg   <= '0;
    end else if (CE_IN) begin
      ls_on_reg <= ls_on_next;
      dch_reg   <= dch_next;
    end
  end

  // read data and refusal pulse
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      rdata_reg   <= 8'h00;
      refused_reg <= 1'b0;
    end else if (CE_IN) begin
      if (REG_RD_IN) begin
        rdata_reg <= rdata_next;
      end
      refused_reg <= wr_locked;  // RULE1
    end
  end

  sbc_blank_timer #(
    .BLANK_CYCLES (BLANK_CYCLES)
  ) u_blank (
    .clk_in (REF_CLK_IN),
    .rst_in (RST_IN),
    .ctl    (ctl)
  );

  sbc_volt_lut u_lut (
    .ctl (ctl)
  );

  // outputs straight from flops
  assign REG_RDATA_OUT    = rdata_reg;
  assign WR_REFUSED_OUT   = refused_reg;
  assign LS_ON_OUT        = ls_on_reg;
  assign LS_DISCHARGE_OUT = dch_reg;
  assign PULSE_SKIP_OUT   = buck_reg[`SBC_BIT_PFM];  // RULE13
  assign BUCK_VCODE_OUT   = vcode_reg;
  assign BUCK_MV_OUT      = mv_reg;
  assign NO_SLEW_OUT      = no_slew_reg;
  assign SUPV_BLANK_OUT   = ctl.blank;

  // checks
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);

  property p_pw_lock;
    CE_IN && wr_locked |=> $stable(sw_cfg_reg) && $stable(buck_reg) && WR_REFUSED_OUT;
  endproperty
  a_pw_lock: assert property (p_pw_lock) else $error("locked write changed a register");  // RULE1

  property p_cfg_rst;
    $past(RST_IN) |-> sw_cfg_reg == 8'h00 && LS_ON_OUT == 3'h0;
  endproperty
  a_cfg_rst: assert property (p_cfg_rst) else $error("switch config not zero after reset");  // RULE2

  property p_cfg_read;
    CE_IN && REG_RD_IN && REG_ADDR_IN == 8'h15 |=> REG_RDATA_OUT == $past(sw_cfg_reg);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("switch config not read at its address");  // RULE2

  property p_sw3_pf;
    CE_IN && pfo_low && sw_cfg_reg[5] |=> !LS_ON_OUT[2];
  endproperty
  a_sw3_pf: assert property (p_sw3_pf) else $error("switch three on during power fail");  // RULE3

  property p_sw2_pf;
    CE_IN && pfo_low && sw_cfg_reg[4] |=> !LS_ON_OUT[1];
  endproperty
  a_sw2_pf: assert property (p_sw2_pf) else $error("switch two on during power fail");  // RULE4

  property p_sw1_pf;
    CE_IN && pfo_low && sw_cfg_reg[3] |=> !LS_ON_OUT[0];
  endproperty
  a_sw1_pf: assert property (p_sw1_pf) else $error("switch one on during power fail");  // RULE5

  property p_pf_ignore;
    CE_IN && sw_cfg_reg[5:3] == 3'h0 |=> LS_ON_OUT == $past(LS_EN_IN);
  endproperty
  a_pf_ignore: assert property (p_pf_ignore) else $error("switch affected with gating off");  // RULE6

  property p_dch3;
    CE_IN |=> LS_DISCHARGE_OUT[2] == ($past(sw_cfg_reg[2]) && !LS_ON_OUT[2]);
  endproperty
  a_dch3: assert property (p_dch3) else $error("switch three discharge wrong");  // RULE7

  property p_dch2;
    CE_IN |=> LS_DISCHARGE_OUT[1] == ($past(sw_cfg_reg[1]) && !LS_ON_OUT[1]);
  endproperty
  a_dch2: assert property (p_dch2) else $error("switch two discharge wrong");  // RULE8

  property p_dch1;
    CE_IN |=> LS_DISCHARGE_OUT[0] == ($past(sw_cfg_reg[0]) && !LS_ON_OUT[0]);
  endproperty
  a_dch1: assert property (p_dch1) else $error("switch one discharge wrong");  // RULE9

  property p_buck_rst;
    $past(RST_IN) |-> buck_reg == 8'h99 && BUCK_MV_OUT == 11'h44c && PULSE_SKIP_OUT;
  endproperty
  a_buck_rst: assert property (p_buck_rst) else $error("buck register reset value wrong");  // RULE10

  property p_blank_start;
    CE_IN && wr_buck_ok |=> SUPV_BLANK_OUT;
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("no blanking after buck write");  // RULE11

  property p_apply_hold;
    CE_IN && !apply |=> $stable(BUCK_VCODE_OUT);
  endproperty
  a_apply_hold: assert property (p_apply_hold) else $error("voltage changed without apply");  // RULE12

  property p_apply_load;
    CE_IN && apply |=> BUCK_VCODE_OUT == $past(buck_reg[5:0]);
  endproperty
  a_apply_load: assert property (p_apply_load) else $error("apply did not load code");  // RULE12

  property p_pfm;
    CE_IN && wr_buck_ok |=> PULSE_SKIP_OUT == $past(REG_WDATA_IN[7]);
  endproperty
  a_pfm: assert property (p_pfm) else $error("pulse-skip bit not written");  // RULE13

  property p_mv_fine;
    BUCK_VCODE_OUT == 6'h23 |-> BUCK_MV_OUT == 11'h4b0;
  endproperty
  a_mv_fine: assert property (p_mv_fine) else $error("code 23h not 1200 mV");  // RULE14

  property p_mv_wide;
    BUCK_VCODE_OUT == 6'h3f |-> BUCK_MV_OUT == 11'h68b;
  endproperty
  a_mv_wide: assert property (p_mv_wide) else $error("code 3fh not 1675 mV");  // RULE15

  c_pf_trip: cover property (CE_IN && pfo_low && pf_off_en != 3'h0 ##1 LS_DISCHARGE_OUT != 3'h0);
  c_locked:  cover property (CE_IN && wr_locked);
  c_noslew:  cover property (CE_IN && APPLY_NOSLEW_IN ##1 NO_SLEW_OUT);
  c_blank:   cover property (CE_IN && wr_buck_ok ##1 SUPV_BLANK_OUT);
endmodule
`default_nettype wire

// ===== hdl/sbc_volt_lut.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.svh"
// voltage code to millivolts, fine steps then wide steps
module sbc_volt_lut (
  sbc_ctl_if.lut ctl
);
  import sbc_pkg::*;
  sbc_mv_t mv_fine;
  sbc_mv_t mv_wide;
  sbc_mv_t code_w;
  sbc_mv_t knee_w;

  // both branches computed, knee selects
  assign code_w  = 11'(ctl.code);
  assign knee_w  = 11'(`SBC_VCODE_KNEE);
  assign mv_fine = `SBC_MV_BASE + code_w * `SBC_MV_STEP_FINE;  // RULE14
  assign mv_wide = `SBC_MV_KNEE + (code_w - knee_w) * `SBC_MV_STEP_WIDE;  // RULE15
  assign ctl.mv  = (ctl.code <= `SBC_VCODE_KNEE) ? mv_fine : mv_wide;
endmodule
`default_nettype wire

// ===== inc/sbc_consts.svh
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// register sub-addresses
`define SBC_ADDR_SW_CFG   8'h15
`define SBC_ADDR_BUCK1    8'h16

// reset values and writable masks
`define SBC_SW_CFG_RST    8'h00
`define SBC_SW_CFG_MASK   8'h3f
`define SBC_BUCK1_RST     8'h99
`define SBC_BUCK1_MASK    8'hbf
`define SBC_VCODE_RST     6'h19

// field positions
`define SBC_BIT_PFM       7
`define SBC_OFF_HI        5
`define SBC_OFF_LO        3
`define SBC_DCH_HI        2
`define SBC_DCH_LO        0
`define SBC_VCODE_HI      5

// voltage code to millivolt mapping
`define SBC_MV_BASE       11'h352
`define SBC_MV_STEP_FINE  11'h00a
`define SBC_VCODE_KNEE    6'h32
`define SBC_MV_KNEE       11'h546
`define SBC_MV_STEP_WIDE  11'h019
`define SBC_MV_RST        11'h44c

// supervisor blanking after a buck write
`define SBC_BLANK_MS      5
`define SBC_CLK_MHZ       250
`define SBC_BLANK_CYCLES  (`SBC_BLANK_MS * 1000 * `SBC_CLK_MHZ)
`define SBC_BLANK_CNT_W   21

`endif

// ===== inc/sbc_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
// links the register core with the blank timer and voltage lookup
interface sbc_ctl_if;
  import sbc_pkg::*;
  logic       ce;
  logic       start;
  logic       blank;
  sbc_vcode_t code;
  sbc_mv_t    mv;
  modport core  (output ce, output start, output code, input blank, input mv);
  modport timer (input ce, input start, output blank);
  modport lut   (input code, output mv);
endinterface
`default_nettype wire

// ===== inc/sbc_pkg.sv
package sbc_pkg;
  typedef logic [7:0]  sbc_byte_t;
  typedef logic [5:0]  sbc_vcode_t;
  typedef logic [10:0] sbc_mv_t;
  typedef logic [2:0]  sbc_sw_t;
endpackage
